// [verilog/t2crb_timer.sv]
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module t2crb_timer #(
  parameter int PERIPH_DIV_6T_P  = t2crb_pkg::PERIPH_DIV_6T,
  parameter int PERIPH_DIV_12T_P = t2crb_pkg::PERIPH_DIV_12T
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [t2crb_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [t2crb_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [t2crb_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [t2crb_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          count_clock_pin_in,
  output logic                               count_clock_pin_out,
  output logic                               count_clock_pin_oe,
  input  wire logic                          trigger_pin_in,
  output logic                               uart_tx_clock_tick,
  output logic                               uart_rx_clock_tick,
  output logic                               timer_irq
);

  function automatic logic reg_hit(input logic [t2crb_pkg::ADDR_W-1:0] addr,
                                   input logic [7:0] idx);
    reg_hit = (addr[t2crb_pkg::ADDR_W-1:2] == {2'h0, idx});
  endfunction : reg_hit

  t2crb_pkg::t2crb_control_type   ctrl_reg;
  t2crb_pkg::t2crb_mode_type      mode;
  logic [7:0]                     mode_reg;
  logic [7:0]                     rcap_low_reg;
  logic [7:0]                     rcap_high_reg;
  logic [15:0]                    count_reg;
  logic                           clk_out_reg;
  logic [3:0]                     presc_reg;
  logic [3:0]                     presc_div;
  logic                           tick;
  logic                           cnt_inc;
  logic                           overflow;
  logic                           clock_out_enable;
  logic                           clock_mode_option;
  logic                           fast_mode;
  logic [1:0]                     pin_sync1_reg;
  logic [1:0]                     pin_sync2_reg;
  logic [1:0]                     pin_sync3_reg;
  logic [1:0]                     pin_fall;
  logic                           trig_fall;
  logic                           count_fall;
  logic                           aw_full_reg;
  logic                           w_full_reg;
  logic [t2crb_pkg::ADDR_W-1:0]   wr_addr_reg;
  logic [7:0]                     wr_data_reg;
  logic                           wr_lane0_reg;
  logic                           bvalid_reg;
  logic [1:0]                     bresp_reg;
  logic                           rvalid_reg;
  logic [1:0]                     rresp_reg;
  logic [7:0]                     rdata_reg;
  logic                           wr_fire;
  logic                           wr_mapped;
  logic                           wr_ctrl;
  logic                           wr_mode;
  logic                           wr_rcap_low;
  logic                           wr_rcap_high;
  logic                           wr_cnt_low;
  logic                           wr_cnt_high;
  logic                           ovf_set;
  logic                           ext_set;
  logic                           uart_tx_reg;
  logic                           uart_rx_reg;

  assign clock_out_enable  = mode_reg[t2crb_pkg::MODE_CLK_OUT_BIT];
  assign clock_mode_option = mode_reg[t2crb_pkg::MODE_CLK_OPT_BIT];

  // clock-out beats the serial selects unless capture_reload_select is set, so the pin never floats mid-frame
  always_comb begin
    if (clock_out_enable && !ctrl_reg.capture_reload_select) begin
      mode = t2crb_pkg::MODE_CLKOUT;
    end else if (ctrl_reg.receive_clock_select || ctrl_reg.transmit_clock_select) begin
      mode = t2crb_pkg::MODE_BAUD;
    end else if (ctrl_reg.capture_reload_select) begin
      mode = t2crb_pkg::MODE_CAPTURE;
    end else begin
      mode = t2crb_pkg::MODE_RELOAD;
    end
  end

  // pin synchronisers: index 0 count pin, index 1 trigger pin
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_sync1_reg[gi] <= 1'b1;
          pin_sync2_reg[gi] <= 1'b1;
          pin_sync3_reg[gi] <= 1'b1;
        end else begin
          pin_sync1_reg[gi] <= (gi == 0) ? count_clock_pin_in : trigger_pin_in;
          pin_sync2_reg[gi] <= pin_sync1_reg[gi];
          pin_sync3_reg[gi] <= pin_sync2_reg[gi];
        end
      end
      assign pin_fall[gi] = pin_sync3_reg[gi] && !pin_sync2_reg[gi];
    end
  endgenerate

  assign trig_fall  = pin_fall[1] && ctrl_reg.external_enable;
  // count pin edges are ignored in clock-out mode, where the pin is an output unless counter_timer_select is set
  assign count_fall = pin_fall[0] && (mode != t2crb_pkg::MODE_CLKOUT);

  // baud and clock-out modes count at the fast rate, the others at the peripheral rate
  assign fast_mode = (mode == t2crb_pkg::MODE_BAUD) || (mode == t2crb_pkg::MODE_CLKOUT);

  always_comb begin
    if (fast_mode) begin
      presc_div = clock_mode_option ? 4'(t2crb_pkg::FAST_DIV_12T)
                                    : 4'(t2crb_pkg::FAST_DIV_6T);
    end else begin
      presc_div = clock_mode_option ? 4'(PERIPH_DIV_12T_P) : 4'(PERIPH_DIV_6T_P);
    end
  end

  assign tick = (presc_reg >= presc_div - 4'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_reg <= 4'h0;
    end else if (tick) begin
      presc_reg <= 4'h0;
    end else begin
      presc_reg <= presc_reg + 4'h1;
    end
  end

  assign cnt_inc  = ctrl_reg.run_control
                    && (ctrl_reg.counter_timer_select ? count_fall : tick);
  assign overflow = cnt_inc && (count_reg == t2crb_pkg::COUNT_ALL_ONES);

  assign ovf_set  = overflow && ((mode == t2crb_pkg::MODE_CAPTURE)
                    || (mode == t2crb_pkg::MODE_RELOAD));
  assign ext_set  = trig_fall;

  // counter; a software byte write wins over counting in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= t2crb_pkg::COUNT_RESET;
    end else if (wr_cnt_low || wr_cnt_high) begin
      if (wr_cnt_low) begin
        count_reg[7:0] <= wr_data_reg;
      end
      if (wr_cnt_high) begin
        count_reg[15:8] <= wr_data_reg;
      end
    end else if (mode == t2crb_pkg::MODE_RELOAD && trig_fall) begin
      count_reg <= {rcap_high_reg, rcap_low_reg};
    end else if (overflow && mode != t2crb_pkg::MODE_CAPTURE) begin
      count_reg <= {rcap_high_reg, rcap_low_reg};
    end else if (cnt_inc) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // capture bytes double as reload bytes outside capture mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rcap_low_reg  <= t2crb_pkg::RCAP_RESET;
      rcap_high_reg <= t2crb_pkg::RCAP_RESET;
    end else if (mode == t2crb_pkg::MODE_CAPTURE && trig_fall) begin
      rcap_low_reg  <= count_reg[7:0];
      rcap_high_reg <= count_reg[15:8];
    end else begin
      if (wr_rcap_low) begin
        rcap_low_reg <= wr_data_reg;
      end
      if (wr_rcap_high) begin
        rcap_high_reg <= wr_data_reg;
      end
    end
  end

  // flags: a hardware set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= t2crb_pkg::t2crb_control_type'(t2crb_pkg::CONTROL_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= t2crb_pkg::t2crb_control_type'(wr_data_reg);
      end
      if (ovf_set) begin
        ctrl_reg.overflow_flag <= 1'b1;
      end
      if (ext_set) begin
        ctrl_reg.external_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= t2crb_pkg::MODE_RESET;
    end else if (wr_mode) begin
      mode_reg <= wr_data_reg;
    end
  end

  // each overflow toggles, so high and low phases span the same count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_out_reg <= 1'b0;
    end else if (mode == t2crb_pkg::MODE_CLKOUT && overflow) begin
      clk_out_reg <= !clk_out_reg;
    end
  end

  assign count_clock_pin_out = clk_out_reg;
  assign count_clock_pin_oe  = clock_out_enable && !ctrl_reg.counter_timer_select;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uart_tx_reg <= 1'b0;
      uart_rx_reg <= 1'b0;
    end else begin
      uart_tx_reg <= overflow && ctrl_reg.transmit_clock_select;
      uart_rx_reg <= overflow && ctrl_reg.receive_clock_select;
    end
  end

  assign uart_tx_clock_tick = uart_tx_reg;
  assign uart_rx_clock_tick = uart_rx_reg;
  assign timer_irq          = ctrl_reg.overflow_flag || ctrl_reg.external_flag;

  // AXI4-Lite write: address and data held independently until both arrive
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready  = !w_full_reg;
  assign wr_fire       = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_mapped     = reg_hit(wr_addr_reg, t2crb_pkg::IDX_CONTROL)
                         || reg_hit(wr_addr_reg, t2crb_pkg::IDX_MODE)
                         || reg_hit(wr_addr_reg, t2crb_pkg::IDX_RCAP_LOW)
                         || reg_hit(wr_addr_reg, t2crb_pkg::IDX_RCAP_HIGH)
                         || reg_hit(wr_addr_reg, t2crb_pkg::IDX_CNT_LOW)
                         || reg_hit(wr_addr_reg, t2crb_pkg::IDX_CNT_HIGH);
  assign wr_ctrl       = wr_fire && wr_lane0_reg && reg_hit(wr_addr_reg, t2crb_pkg::IDX_CONTROL);
  assign wr_mode       = wr_fire && wr_lane0_reg && reg_hit(wr_addr_reg, t2crb_pkg::IDX_MODE);
  assign wr_rcap_low   = wr_fire && wr_lane0_reg
                         && reg_hit(wr_addr_reg, t2crb_pkg::IDX_RCAP_LOW);
  assign wr_rcap_high  = wr_fire && wr_lane0_reg
                         && reg_hit(wr_addr_reg, t2crb_pkg::IDX_RCAP_HIGH);
  assign wr_cnt_low    = wr_fire && wr_lane0_reg && reg_hit(wr_addr_reg, t2crb_pkg::IDX_CNT_LOW);
  assign wr_cnt_high   = wr_fire && wr_lane0_reg
                         && reg_hit(wr_addr_reg, t2crb_pkg::IDX_CNT_HIGH);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else if (s_axi_awvalid && !aw_full_reg) begin
      aw_full_reg <= 1'b1;
      wr_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg   <= 1'b0;
      wr_data_reg  <= 8'h00;
      wr_lane0_reg <= 1'b0;
    end else if (s_axi_wvalid && !w_full_reg) begin
      w_full_reg   <= 1'b1;
      wr_data_reg  <= s_axi_wdata[7:0];
      wr_lane0_reg <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= t2crb_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_mapped ? t2crb_pkg::RESP_OKAY : t2crb_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // AXI4-Lite read: one outstanding, data latched at the address handshake
  assign s_axi_arready = !rvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= t2crb_pkg::RESP_OKAY;
      rdata_reg  <= 8'h00;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= t2crb_pkg::RESP_OKAY;
      if (reg_hit(s_axi_araddr, t2crb_pkg::IDX_CONTROL)) begin
        rdata_reg <= ctrl_reg;
      end else if (reg_hit(s_axi_araddr, t2crb_pkg::IDX_MODE)) begin
        rdata_reg <= mode_reg;
      end else if (reg_hit(s_axi_araddr, t2crb_pkg::IDX_RCAP_LOW)) begin
        rdata_reg <= rcap_low_reg;
      end else if (reg_hit(s_axi_araddr, t2crb_pkg::IDX_RCAP_HIGH)) begin
        rdata_reg <= rcap_high_reg;
      end else if (reg_hit(s_axi_araddr, t2crb_pkg::IDX_CNT_LOW)) begin
        rdata_reg <= count_reg[7:0];
      end else if (reg_hit(s_axi_araddr, t2crb_pkg::IDX_CNT_HIGH)) begin
        rdata_reg <= count_reg[15:8];
      end else begin
        rdata_reg <= 8'h00;
        rresp_reg <= t2crb_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = {24'h000000, rdata_reg};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_overflow_sets_flag: assert property (
    overflow && mode == t2crb_pkg::MODE_CAPTURE |=> ctrl_reg.overflow_flag && count_reg == 16'h0000
  ) else $error("capture overflow did not set flag or wrap");

  a_no_flag_baud: assert property (
    (mode == t2crb_pkg::MODE_BAUD || mode == t2crb_pkg::MODE_CLKOUT)
    && !ctrl_reg.overflow_flag && !wr_ctrl |=> !ctrl_reg.overflow_flag
  ) else $error("overflow flag set in baud or clock-out mode");

  a_capture_copy: assert property (
    mode == t2crb_pkg::MODE_CAPTURE && trig_fall
    |=> {rcap_high_reg, rcap_low_reg} == $past(count_reg) && ctrl_reg.external_flag
  ) else $error("capture did not copy counter or set external flag");

  a_reload_load: assert property (
    overflow && mode != t2crb_pkg::MODE_CAPTURE && !wr_cnt_low && !wr_cnt_high
    |=> count_reg == $past({rcap_high_reg, rcap_low_reg})
  ) else $error("overflow did not reload counter");

  a_count_steps: assert property (
    cnt_inc && count_reg != 16'hFFFF && !wr_cnt_low && !wr_cnt_high && !trig_fall
    |=> count_reg == $past(count_reg) + 16'h0001
  ) else $error("counter did not increment by one");

  a_halt_holds: assert property (
    !ctrl_reg.run_control && !wr_cnt_low && !wr_cnt_high && !trig_fall |=> $stable(count_reg)
  ) else $error("halted counter changed");

  a_flag_sticky: assert property (
    !wr_ctrl |=> (ctrl_reg.overflow_flag || !$past(ctrl_reg.overflow_flag))
                 && (ctrl_reg.external_flag || !$past(ctrl_reg.external_flag))
  ) else $error("flag cleared without software write");

  a_no_capture_off: assert property (
    !ctrl_reg.external_enable && !wr_rcap_low && !wr_rcap_high
    |=> $stable({rcap_high_reg, rcap_low_reg})
  ) else $error("capture bytes changed with external enable off");

  a_clkout_toggle: assert property (
    mode == t2crb_pkg::MODE_CLKOUT && overflow |=> clk_out_reg != $past(clk_out_reg)
  ) else $error("clock-out did not toggle on overflow");

  a_uart_tick: assert property (
    overflow && ctrl_reg.transmit_clock_select && !ctrl_reg.receive_clock_select
    |=> uart_tx_clock_tick && !uart_rx_clock_tick
  ) else $error("transmit tick not independent of receive");

  a_irq_shared: assert property (
    ext_set |=> timer_irq
  ) else $error("external event raised no interrupt");

  c_capture: cover property (mode == t2crb_pkg::MODE_CAPTURE && trig_fall);
  c_reload: cover property (mode == t2crb_pkg::MODE_RELOAD && overflow);
  c_clkout: cover property (mode == t2crb_pkg::MODE_CLKOUT && overflow);
  c_baud: cover property (mode == t2crb_pkg::MODE_BAUD && overflow);

endmodule : t2crb_timer
`default_nettype wire

// [verilog/t2crb_pkg.sv]
package t2crb_pkg;

  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CONTROL    = 8'hC8;
  localparam logic [7:0]  IDX_MODE       = 8'hC9;
  localparam logic [7:0]  IDX_RCAP_LOW   = 8'hCA;
  localparam logic [7:0]  IDX_RCAP_HIGH  = 8'hCB;
  localparam logic [7:0]  IDX_CNT_LOW    = 8'hCC;
  localparam logic [7:0]  IDX_CNT_HIGH   = 8'hCD;

  localparam int          MODE_CLK_OUT_BIT = 1;
  localparam int          MODE_CLK_OPT_BIT = 4;

  localparam logic [7:0]  CONTROL_RESET  = 8'h00;
  localparam logic [7:0]  MODE_RESET     = 8'h00;
  localparam logic [7:0]  RCAP_RESET     = 8'h00;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;

  localparam int          PERIPH_DIV_6T  = 6;
  localparam int          PERIPH_DIV_12T = 12;
  localparam int          FAST_DIV_6T    = 1;
  localparam int          FAST_DIV_12T   = 2;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic overflow_flag;
    logic external_flag;
    logic receive_clock_select;
    logic transmit_clock_select;
    logic external_enable;
    logic run_control;
    logic counter_timer_select;
    logic capture_reload_select;
  } t2crb_control_type;

  typedef enum logic [1:0] {
    MODE_CAPTURE,
    MODE_RELOAD,
    MODE_BAUD,
    MODE_CLKOUT
  } t2crb_mode_type;

endpackage : t2crb_pkg

// [tb/t2crb_pins.sv]
`timescale 1ns/1ps
`default_nettype none
module t2crb_pins (
  input  wire logic aclk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic tx_tick,
  input  wire logic rx_tick,
  output logic      count_wire,
  output logic      trig
);
  logic drv  = 1'b1;
  logic trg  = 1'b1;
  logic prev = 1'b0;
  int   tx_n = 0;
  int   rx_n = 0;
  int   run  = 0;
  int   half[2];
  // pulled up when neither side drives the count pin
  assign count_wire = pin_oe ? pin_out : drv;
  assign trig = trg;
  always @(posedge aclk) begin
    tx_n <= tx_n + int'(tx_tick);
    rx_n <= rx_n + int'(rx_tick);
    prev <= pin_out;
    if (pin_out != prev) begin
      half[prev] <= run;
      run <= 1;
    end else run <= run + 1;
  end
  // each level held 8 cycles, well past the 3-stage sampler
  task automatic fall(input bit cnt);
    @(posedge aclk);
    if (cnt) drv <= 1'b0; else trg <= 1'b0;
    repeat (8) @(posedge aclk);
    if (cnt) drv <= 1'b1; else trg <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask : fall
endmodule : t2crb_pins
`default_nettype wire

// [tb/timer2_capture_reload_baud_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module timer2_capture_reload_baud_tb;
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        count_clock_pin_in, count_clock_pin_out, count_clock_pin_oe, trigger_pin_in;
  logic        uart_tx_clock_tick, uart_rx_clock_tick, timer_irq;
  int          fails = 0, tests_run = 0, n, t0, r0;
  always #2 aclk = ~aclk;
  t2crb_timer dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .count_clock_pin_in(count_clock_pin_in), .count_clock_pin_out(count_clock_pin_out),
    .count_clock_pin_oe(count_clock_pin_oe), .trigger_pin_in(trigger_pin_in),
    .uart_tx_clock_tick(uart_tx_clock_tick), .uart_rx_clock_tick(uart_rx_clock_tick),
    .timer_irq(timer_irq));
  t2crb_pins pins (.aclk(aclk), .pin_out(count_clock_pin_out), .pin_oe(count_clock_pin_oe),
    .tx_tick(uart_tx_clock_tick), .rx_tick(uart_rx_clock_tick),
    .count_wire(count_clock_pin_in), .trig(trigger_pin_in));
  task automatic stop_test();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [1:0] rsp(input logic [7:0] idx);
    return idx > t2crb_pkg::IDX_CNT_HIGH ? t2crb_pkg::RESP_SLVERR : t2crb_pkg::RESP_OKAY;
  endfunction : rsp
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bit b = 0;
    @(posedge aclk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !b; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        b = 1;
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, rsp(idx));
      end
    end
    if (!b) begin fails++; stop_test(); end
  endtask : wr
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    bit b = 0;
    @(posedge aclk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && !b; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        b = 1;
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, {24'h0, exp});
        chk(s_axi_rresp, rsp(idx));
      end
    end
    if (!b) begin fails++; stop_test(); end
  endtask : rchk
  task automatic wirq();
    for (n = 0; n < 300 && timer_irq !== 1'b1; n++) @(posedge aclk);
    if (n == 300) begin fails++; stop_test(); end
  endtask : wirq
  task automatic cnt(input logic [7:0] h, input logic [7:0] l);
    wr(t2crb_pkg::IDX_CNT_HIGH, h);
    wr(t2crb_pkg::IDX_CNT_LOW, l);
  endtask : cnt
  task automatic t_reset();
    rchk(t2crb_pkg::IDX_CNT_LOW, 8'h00);
    rchk(t2crb_pkg::IDX_CNT_HIGH, 8'h00);
    // a write with lane 0 off must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(t2crb_pkg::IDX_RCAP_HIGH, 8'hA5);
    s_axi_wstrb <= 4'hF;
    rchk(t2crb_pkg::IDX_RCAP_HIGH, 8'h00);
    rchk(8'hE0, 8'h00);
    wr(8'hE0, 8'h55);
    chk(timer_irq, 1'b0);
  endtask : t_reset
  // timer stopped so the captured value is exact
  task automatic t_capture();
    cnt(8'h12, 8'h34);
    wr(t2crb_pkg::IDX_CONTROL, 8'h09);
    pins.fall(0);
    rchk(t2crb_pkg::IDX_RCAP_HIGH, 8'h12);
    rchk(t2crb_pkg::IDX_RCAP_LOW, 8'h34);
    rchk(t2crb_pkg::IDX_CONTROL, 8'h49);
    chk(timer_irq, 1'b1);
    rchk(t2crb_pkg::IDX_CNT_LOW, 8'h34);
    wr(t2crb_pkg::IDX_CONTROL, 8'h01);
    chk(timer_irq, 1'b0);
    cnt(8'h56, 8'h78);
    pins.fall(0);
    rchk(t2crb_pkg::IDX_RCAP_HIGH, 8'h12);
    rchk(t2crb_pkg::IDX_CONTROL, 8'h01);
    cnt(8'hFF, 8'hFE);
    wr(t2crb_pkg::IDX_CONTROL, 8'h05);
    wirq();
    rchk(t2crb_pkg::IDX_CONTROL, 8'h85);
    wr(t2crb_pkg::IDX_CONTROL, 8'h01);
    rchk(t2crb_pkg::IDX_CNT_HIGH, 8'h00);
  endtask : t_capture
  task automatic t_reload();
    wr(t2crb_pkg::IDX_CONTROL, 8'h00);
    wr(t2crb_pkg::IDX_RCAP_HIGH, 8'hAB);
    wr(t2crb_pkg::IDX_RCAP_LOW, 8'hCD);
    cnt(8'hFF, 8'hFF);
    wr(t2crb_pkg::IDX_CONTROL, 8'h04);
    wirq();
    rchk(t2crb_pkg::IDX_CONTROL, 8'h84);
    wr(t2crb_pkg::IDX_CONTROL, 8'h00);
    rchk(t2crb_pkg::IDX_CNT_HIGH, 8'hAB);
    cnt(8'h11, 8'h22);
    wr(t2crb_pkg::IDX_CONTROL, 8'h08);
    pins.fall(0);
    rchk(t2crb_pkg::IDX_CNT_HIGH, 8'hAB);
    rchk(t2crb_pkg::IDX_CNT_LOW, 8'hCD);
    rchk(t2crb_pkg::IDX_CONTROL, 8'h48);
  endtask : t_reload
  // one select at a time: the other tick line must stay at 5 ticks or fewer
  task automatic t_baud();
    logic [7:0] sel;
    wr(t2crb_pkg::IDX_RCAP_HIGH, 8'hFF);
    wr(t2crb_pkg::IDX_RCAP_LOW, 8'hF0);
    for (int k = 0; k < 2; k++) begin
      sel = k ? 8'h28 : 8'h18;
      cnt(8'hFF, 8'hF0);
      t0 = pins.tx_n;
      r0 = pins.rx_n;
      wr(t2crb_pkg::IDX_CONTROL, sel | 8'h04);
      repeat (160) @(posedge aclk);
      wr(t2crb_pkg::IDX_CONTROL, sel);
      chk(pins.tx_n > t0 + 5, k == 0);
      chk(pins.rx_n > r0 + 5, k == 1);
      rchk(t2crb_pkg::IDX_CONTROL, sel);
      pins.fall(0);
      rchk(t2crb_pkg::IDX_CONTROL, sel | 8'h40);
      wr(t2crb_pkg::IDX_CONTROL, 8'h00);
    end
  endtask : t_baud
  task automatic t_clkout();
    wr(t2crb_pkg::IDX_MODE, 8'h02);
    chk(count_clock_pin_oe, 1'b1);
    repeat (60) @(posedge aclk);
    chk(count_clock_pin_out, 1'b0);
    wr(t2crb_pkg::IDX_CONTROL, 8'h0C);
    repeat (200) @(posedge aclk);
    chk(pins.half[0], 16);
    chk(pins.half[1], 16);
    chk(timer_irq, 1'b0);
    wr(t2crb_pkg::IDX_MODE, 8'h12);
    repeat (300) @(posedge aclk);
    chk(pins.half[1], 32);
    pins.fall(0);
    rchk(t2crb_pkg::IDX_CONTROL, 8'h4C);
    wr(t2crb_pkg::IDX_CONTROL, 8'h00);
    wr(t2crb_pkg::IDX_MODE, 8'h00);
    chk(count_clock_pin_oe, 1'b0);
  endtask : t_clkout
  // three pin falls in 51 cycles; prescaler counting would give more
  task automatic t_counter();
    cnt(8'h00, 8'h00);
    wr(t2crb_pkg::IDX_CONTROL, 8'h06);
    repeat (3) pins.fall(1);
    wr(t2crb_pkg::IDX_CONTROL, 8'h02);
    rchk(t2crb_pkg::IDX_CNT_LOW, 8'h03);
    repeat (40) @(posedge aclk);
    rchk(t2crb_pkg::IDX_CNT_LOW, 8'h03);
  endtask : t_counter
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_capture();
    t_reload();
    t_baud();
    t_clkout();
    t_counter();
    stop_test();
  end
endmodule : timer2_capture_reload_baud_tb
`default_nettype wire
